// *** hw/smtc_map.vh ***
// Constants of the single-mode thermostat control block.
`ifndef SMTC_MAP_VH
`define SMTC_MAP_VH
// ============================================================
// Register offsets (8-bit address space)
`define SMTC_A_CTRL        8'h00
`define SMTC_A_OCC_COOL    8'h01
`define SMTC_A_OCC_HEAT    8'h02
`define SMTC_A_UNOCC_COOL  8'h03
`define SMTC_A_UNOCC_HEAT  8'h04
`define SMTC_A_TYPE        8'h05
`define SMTC_A_OPTIONS     8'h06
`define SMTC_A_STATUS      8'h07
`define SMTC_A_ACTIVE_SP   8'h08
`define SMTC_A_ROOM_TEMP   8'h09
// ============================================================
// CTRL bit positions
`define SMTC_C_POWER       0
`define SMTC_C_VENT        1
`define SMTC_C_FAN_CONT    2
`define SMTC_C_UNOCC       3
`define SMTC_C_SET_LOCK    4
`define SMTC_C_FAN_IN_HEAT 5
`define SMTC_C_DISP_SP     6
// CTRL reset value: off, heat/cool, fan auto, occupied, fan in heat on.
`define SMTC_CTRL_RST      7'h20
// ============================================================
// Control type codes
`define SMTC_TYPE_COOL     2'h1
`define SMTC_TYPE_HEAT     2'h2
// Setpoint reset value, 0.5 degree steps (21.0 degrees).
`define SMTC_SP_RST        8'h2A
// ============================================================
// Timing
`define SMTC_CLK_HZ        10000000
`define SMTC_MENU_S        10
`define SMTC_WINDOW_S      60
`define SMTC_FANOFF_S      120
`define SMTC_BLINK_CYC     5000000
`endif

// *** hw/smtc_top.v ***
// Single-mode thermostat panel and network control block.
// Behaviour
// R1 - Power button and network toggle on/off; off holds heat, cool and fan disabled.
// R2 - Mode button toggles heat/cool versus ventilation; up/down rotate permitted choices.
// R3 - Up raises and down lowers active setpoint; inside a setting they rotate it.
// R4 - Fan button toggles auto/continuous; continuous keeps fan on, clears auto indicator.
// R5 - Auto indicator flashes during fan off-delay; fan stops when delay expires.
// R6 - Set then up/down toggles pending occupancy; applied by set or mode.
// R7 - Set lock stops set-button presses from changing occupancy.
// R8 - Menu ends after 10 seconds without a panel button press.
// R9 - Display shows room temperature or setpoint per display option.
// R10 - Network writes of the four setpoints force active setpoint values.
// R11 - Control type defaults to heating only after manufacture.
// R12 - Factory reset keeps stored control type and operating mode.
// R13 - Network type write of 1 or 2 accepted only within options window.
// R14 - One minute after options set, options clear to 0 and type locks.
// R15 - Local changeover: options set, menu timed out, mode then up/down swaps type.
// R16 - Cooling type uses cool setpoints, heating type heat ones, by occupancy.
// R17 - No deadband is applied between heating and cooling setpoints.
// R18 - Fan-in-heat setting, default 1, gates fan output during heating.
// R19 - Changeover window timed from options write; rewrite restarts it.
// R20 - Latest of button press or network write to a setting wins.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "smtc_map.vh"

module smtc_top #(
   parameter MENU_CYC   = `SMTC_CLK_HZ * `SMTC_MENU_S,
   parameter WINDOW_CYC = `SMTC_CLK_HZ * `SMTC_WINDOW_S,
   parameter FANOFF_CYC = `SMTC_CLK_HZ * `SMTC_FANOFF_S,
   parameter BLINK_CYC  = `SMTC_BLINK_CYC
) (
   // Clock and reset.
   input  wire       clock,
   input  wire       rstn,
   // Panel buttons, one-cycle press pulses.
   input  wire       btn_mode,
   input  wire       btn_fan,
   input  wire       btn_up,
   input  wire       btn_down,
   input  wire       btn_set,
   input  wire       btn_power,
   // Factory reset pulse.
   input  wire       factory_reset,
   // Plant inputs.
   input  wire [7:0] room_temp,
   input  wire       demand,
   input  wire       fan_delay_req,
   // Register port.
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // Plant outputs.
   output reg        heat_out,
   output reg        cool_out,
   output reg        fan_out,
   output reg  [7:0] active_sp,
   // Display.
   output reg  [7:0] disp_value,
   output reg        auto_icon,
   output reg        menu_active,
   output reg        unocc_icon
);

   // ============================================================
   // Panel state machine states
   // Normal display, mode, occupancy and type menus.
   // One-hot codes keep each state test to one flip-flop.
   localparam [3:0] ST_NORMAL = 4'b0001;
   localparam [3:0] ST_MODE   = 4'b0010;
   localparam [3:0] ST_OCC    = 4'b0100;
   localparam [3:0] ST_TYPE   = 4'b1000;

   // The control bits sit in one word so a network write replaces them at once.
   reg [3:0]  state_r;
   reg [6:0]  ctrl_r;
   reg        pend_unocc_r;
   reg [1:0]  type_r;
   reg        opt_r;
   reg        opt_timed_out_r;
   // Four stored setpoints; type and occupancy pick the one in force.
   reg [7:0]  occ_cool_r;
   reg [7:0]  occ_heat_r;
   reg [7:0]  unocc_cool_r;
   reg [7:0]  unocc_heat_r;

   // Timers are 32 bits so the two-minute fan delay fits at full rate.
   reg [31:0] menu_cnt_r;
   reg [31:0] win_cnt_r;
   reg [31:0] fan_cnt_r;
   reg [31:0] blink_cnt_r;
   reg        blink_r;
   reg        fan_delay_r;

   // Presses arrive as one-cycle pulses, so no edge detection is needed.
   wire any_btn = btn_mode | btn_fan | btn_up | btn_down | btn_set | btn_power;
   wire updn    = btn_up | btn_down;
   wire is_heat = (type_r == `SMTC_TYPE_HEAT);
   wire wr_ctrl = reg_wr && (reg_addr == `SMTC_A_CTRL);
   wire wr_opt  = reg_wr && (reg_addr == `SMTC_A_OPTIONS);
   wire wr_type = reg_wr && (reg_addr == `SMTC_A_TYPE);
   wire win_open = opt_r;
   wire type_ok  = (reg_wdata[1:0] == `SMTC_TYPE_COOL) || (reg_wdata[1:0] == `SMTC_TYPE_HEAT);
   wire unocc   = ctrl_r[`SMTC_C_UNOCC];

   // Setpoint that the up/down keys act on in normal operation.
   wire [1:0] sp_sel = {unocc, is_heat};

   // ============================================================
   // Menu state machine, options window and control bits.
   // Factory reset deliberately leaves type_r and the operating mode alone.
   // Network writes come after the button logic so they win a same-cycle tie.
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r         <= ST_NORMAL;
         ctrl_r          <= `SMTC_CTRL_RST;
         pend_unocc_r    <= 1'b0;
         type_r          <= `SMTC_TYPE_HEAT;              // see R11
         opt_r           <= 1'b0;
         opt_timed_out_r <= 1'b0;
         menu_cnt_r      <= 32'h0000_0000;
         win_cnt_r       <= 32'h0000_0000;
         occ_cool_r      <= `SMTC_SP_RST;
         occ_heat_r      <= `SMTC_SP_RST;
         unocc_cool_r    <= `SMTC_SP_RST;
         unocc_heat_r    <= `SMTC_SP_RST;
      end
      else
      begin
         // Menu inactivity timer; any press restarts it.
         // It stops at its limit, so a long quiet spell cannot wrap it.
         if (any_btn)
            menu_cnt_r <= 32'h0000_0000;
         else if (state_r != ST_NORMAL && menu_cnt_r < MENU_CYC - 1)
            menu_cnt_r <= menu_cnt_r + 32'h0000_0001;

         // Button handling; network writes below come later in the block, so a
         // write in the same cycle as a press is treated as the later one.
         case (state_r)
            ST_NORMAL:
            begin
               // Power and fan toggle at once and never open a menu.
               if (btn_power)
                  ctrl_r[`SMTC_C_POWER] <= ~ctrl_r[`SMTC_C_POWER];   // see R1
               if (btn_fan)
                  ctrl_r[`SMTC_C_FAN_CONT] <= ~ctrl_r[`SMTC_C_FAN_CONT];   // see R4
               if (btn_mode)
               begin
                  ctrl_r[`SMTC_C_VENT] <= ~ctrl_r[`SMTC_C_VENT];   // see R2
                  state_r <= (opt_r && opt_timed_out_r) ? ST_TYPE : ST_MODE;   // see R15
               end
               else if (btn_set && !ctrl_r[`SMTC_C_SET_LOCK])   // see R7
               begin
                  pend_unocc_r <= unocc;
                  state_r      <= ST_OCC;
               end
               else if (updn)
               begin
                  // Setpoint step of one unit, saturating; single setpoint, no deadband.
                  case (sp_sel)   // see R3, R17
                     2'b00: occ_cool_r <= btn_up ? ((occ_cool_r == 8'hFF) ? occ_cool_r
                                        : occ_cool_r + 8'h01) : ((occ_cool_r == 8'h00)
                                        ? occ_cool_r : occ_cool_r - 8'h01);
                     2'b01: occ_heat_r <= btn_up ? ((occ_heat_r == 8'hFF) ? occ_heat_r
                                        : occ_heat_r + 8'h01) : ((occ_heat_r == 8'h00)
                                        ? occ_heat_r : occ_heat_r - 8'h01);
                     2'b10: unocc_cool_r <= btn_up ? ((unocc_cool_r == 8'hFF) ? unocc_cool_r
                                        : unocc_cool_r + 8'h01) : ((unocc_cool_r == 8'h00)
                                        ? unocc_cool_r : unocc_cool_r - 8'h01);
                     default: unocc_heat_r <= btn_up ? ((unocc_heat_r == 8'hFF) ? unocc_heat_r
                                        : unocc_heat_r + 8'h01) : ((unocc_heat_r == 8'h00)
                                        ? unocc_heat_r : unocc_heat_r - 8'h01);
                  endcase
               end
            end
            ST_MODE:
            begin
               // Only heat/cool and ventilate are permitted in single mode.
               if (updn)
                  ctrl_r[`SMTC_C_VENT] <= ~ctrl_r[`SMTC_C_VENT];   // see R2, R3
               else if (btn_mode || btn_set)
                  state_r <= ST_NORMAL;
            end
            ST_OCC:
            begin
               // The choice stays pending until set or mode confirms it.
               if (updn)
                  pend_unocc_r <= ~pend_unocc_r;   // see R6
               else if (btn_set || btn_mode)
               begin
                  ctrl_r[`SMTC_C_UNOCC] <= pend_unocc_r;   // see R6
                  state_r <= ST_NORMAL;
               end
            end
            ST_TYPE:
            begin
               // The swap is refused once the options window has closed.
               if (updn && opt_r)
                  type_r <= is_heat ? `SMTC_TYPE_COOL : `SMTC_TYPE_HEAT;   // see R15
               else if (btn_mode || btn_set)
                  state_r <= ST_NORMAL;
            end
            default: state_r <= ST_NORMAL;
         endcase

         // Inactivity abandons any pending, unapplied choice.
         // A press in the same cycle keeps the menu open instead.
         if (state_r != ST_NORMAL && !any_btn && menu_cnt_r >= MENU_CYC - 1)
            state_r <= ST_NORMAL;   // see R8

         // Menu timeout after options set arms the local changeover.
         // The user then has the rest of the window for mode and up or down.
         if (opt_r && state_r != ST_NORMAL && menu_cnt_r >= MENU_CYC - 1)
            opt_timed_out_r <= 1'b1;   // see R15

         // Changeover window: open by writing 1, restart on rewrite, close at one minute.
         // A rewrite also disarms the menu condition until the menu times out again.
         if (wr_opt)
         begin
            opt_r           <= reg_wdata[0];   // see R19
            win_cnt_r       <= 32'h0000_0000;
            opt_timed_out_r <= 1'b0;
         end
         else if (opt_r)
         begin
            if (win_cnt_r >= WINDOW_CYC - 1)
            begin
               opt_r           <= 1'b0;   // see R14
               opt_timed_out_r <= 1'b0;
            end
            else
               win_cnt_r <= win_cnt_r + 32'h0000_0001;
         end

         // Type write refused outside the window or with a bad code.
         // The lock is simply the closed window; no separate lock bit exists.
         if (wr_type && win_open && type_ok)
            type_r <= reg_wdata[1:0];   // see R13

         // Network writes, last writer wins over same-cycle presses.
         if (wr_ctrl)
            ctrl_r <= reg_wdata[6:0];   // see R1, R20
         if (reg_wr && reg_addr == `SMTC_A_OCC_COOL)
            occ_cool_r <= reg_wdata;   // see R10
         if (reg_wr && reg_addr == `SMTC_A_OCC_HEAT)
            occ_heat_r <= reg_wdata;   // see R10
         if (reg_wr && reg_addr == `SMTC_A_UNOCC_COOL)
            unocc_cool_r <= reg_wdata;   // see R10
         if (reg_wr && reg_addr == `SMTC_A_UNOCC_HEAT)
            unocc_heat_r <= reg_wdata;   // see R10

         // Factory reset restores user settings but not type or mode.
         // It comes last so it overrides a same-cycle write.
         if (factory_reset)
         begin
            ctrl_r <= (`SMTC_CTRL_RST & 7'h7D) | (ctrl_r & 7'h02);   // see R12
            occ_cool_r   <= `SMTC_SP_RST;
            occ_heat_r   <= `SMTC_SP_RST;
            unocc_cool_r <= `SMTC_SP_RST;
            unocc_heat_r <= `SMTC_SP_RST;
         end
      end
   end

   // ============================================================
   // Fan off-delay timer and indicator blink.
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         fan_delay_r <= 1'b0;
         fan_cnt_r   <= 32'h0000_0000;
         blink_cnt_r <= 32'h0000_0000;
         blink_r     <= 1'b0;
      end
      else
      begin
         // A new request restarts the delay; continuous mode has no use for it.
         if (fan_delay_req && !ctrl_r[`SMTC_C_FAN_CONT])
         begin
            fan_delay_r <= 1'b1;
            fan_cnt_r   <= 32'h0000_0000;
         end
         else if (fan_delay_r)
         begin
            if (fan_cnt_r >= FANOFF_CYC - 1 || ctrl_r[`SMTC_C_FAN_CONT])
               fan_delay_r <= 1'b0;   // see R5
            else
               fan_cnt_r <= fan_cnt_r + 32'h0000_0001;
         end
         // Free-running blink base for the automatic indicator.
         if (blink_cnt_r >= BLINK_CYC - 1)
         begin
            blink_cnt_r <= 32'h0000_0000;
            blink_r     <= ~blink_r;
         end
         else
            blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
      end
   end

   // ============================================================
   // Registered outputs and read port.
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         // Plant outputs stay low through reset for safety.
         heat_out    <= 1'b0;
         cool_out    <= 1'b0;
         fan_out     <= 1'b0;
         active_sp   <= 8'h00;
         disp_value  <= 8'h00;
         auto_icon   <= 1'b0;
         menu_active <= 1'b0;
         unocc_icon  <= 1'b0;
         reg_rdata   <= 8'h00;
      end
      else
      begin
         // Setpoint chosen by type and occupancy.
         // No deadband: only one setpoint is ever in force.
         case (sp_sel)   // see R16
            2'b00:   active_sp <= occ_cool_r;
            2'b01:   active_sp <= occ_heat_r;
            2'b10:   active_sp <= unocc_cool_r;
            default: active_sp <= unocc_heat_r;
         endcase
         // Heat and cool disabled while off or ventilating; fan disabled only while off.
         // Outside ventilation, fan follows cooling demand always, heating demand only if enabled.
         heat_out <= ctrl_r[`SMTC_C_POWER] && !ctrl_r[`SMTC_C_VENT] && is_heat && demand;   // see R1
         cool_out <= ctrl_r[`SMTC_C_POWER] && !ctrl_r[`SMTC_C_VENT] && !is_heat && demand;
         fan_out  <= ctrl_r[`SMTC_C_POWER] && (ctrl_r[`SMTC_C_FAN_CONT] || fan_delay_r   // see R4, R5
                     || (demand && !ctrl_r[`SMTC_C_VENT]
                         && (!is_heat || ctrl_r[`SMTC_C_FAN_IN_HEAT])));   // see R18
         auto_icon  <= !ctrl_r[`SMTC_C_FAN_CONT] && (!fan_delay_r || blink_r);   // see R4, R5
         disp_value <= ctrl_r[`SMTC_C_DISP_SP] ? active_sp : room_temp;   // see R9
         menu_active <= (state_r != ST_NORMAL);
         unocc_icon  <= unocc;
         // Read data stand for one cycle only and are zero otherwise.
         if (reg_rd)
         begin
            if (reg_addr == `SMTC_A_CTRL)
               reg_rdata <= {1'b0, ctrl_r};
            else if (reg_addr == `SMTC_A_OCC_COOL)
               reg_rdata <= occ_cool_r;
            else if (reg_addr == `SMTC_A_OCC_HEAT)
               reg_rdata <= occ_heat_r;
            else if (reg_addr == `SMTC_A_UNOCC_COOL)
               reg_rdata <= unocc_cool_r;
            else if (reg_addr == `SMTC_A_UNOCC_HEAT)
               reg_rdata <= unocc_heat_r;
            else if (reg_addr == `SMTC_A_TYPE)
               reg_rdata <= {6'h00, type_r};
            else if (reg_addr == `SMTC_A_OPTIONS)
               reg_rdata <= {7'h00, opt_r};
            else if (reg_addr == `SMTC_A_STATUS)
               reg_rdata <= {3'h0, fan_delay_r, fan_out, cool_out, heat_out, menu_active};
            else if (reg_addr == `SMTC_A_ACTIVE_SP)
               reg_rdata <= active_sp;
            else if (reg_addr == `SMTC_A_ROOM_TEMP)
               reg_rdata <= room_temp;
            else
               reg_rdata <= 8'h00;   // Unmapped addresses read as zero.
         end
         else
            reg_rdata <= 8'h00;
      end
   end

endmodule // smtc_top

// *** sim/smtc_top_properties.sv ***
// Port-level checker of the thermostat control block.
`timescale 1ns/1ps
`include "smtc_map.vh"

// ==========================================================
// Checker
module smtc_top_properties #(
   parameter MENU_CYC = 20
) (
   // Clock, reset and inputs.
   input wire       clock,
   input wire       rstn,
   input wire       btn_mode,
   input wire       btn_fan,
   input wire       btn_up,
   input wire       btn_down,
   input wire       btn_set,
   input wire       btn_power,
   input wire       factory_reset,
   input wire [7:0] room_temp,
   input wire       demand,
   input wire [7:0] reg_addr,
   input wire       reg_wr,
   input wire       reg_rd,
   // Outputs watched.
   input wire [7:0] reg_rdata,
   input wire       heat_out,
   input wire       cool_out,
   input wire       fan_out,
   input wire [7:0] active_sp,
   input wire [7:0] disp_value,
   input wire       menu_active,
   input wire       unocc_icon
);
   reg  [15:0] idle_r;
   wire        press = btn_mode | btn_fan | btn_up | btn_down | btn_set | btn_power;
   wire        kick  = press | reg_wr | factory_reset;

   // Idle cycles since the last press; saturates so a long quiet run never wraps.
   always @(posedge clock or negedge rstn)
      if (!rstn) idle_r <= 16'h0000;
      else if (press) idle_r <= 16'h0000;
      else if (idle_r != 16'hFFFF) idle_r <= idle_r + 16'h0001;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   menu_timeout_a: assert property (idle_r > MENU_CYC + 3 |-> !menu_active)
      else $error("menu still open after idle time");
   single_output_a: assert property (!(heat_out && cool_out))
      else $error("heat and cool driven together");
   no_demand_a: assert property (!$past(demand) |-> !heat_out && !cool_out)
      else $error("plant output without demand");
   fan_cool_a: assert property (cool_out |-> fan_out)
      else $error("cooling without fan");
   room_read_a: assert property (reg_rd && reg_addr == `SMTC_A_ROOM_TEMP
      |=> reg_rdata == $past(room_temp))
      else $error("room temperature read wrong");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   disp_source_a: assert property ($past(rstn, 3) |-> disp_value == $past(room_temp)
      || disp_value == $past(active_sp) || disp_value == $past(active_sp, 2))
      else $error("display shows neither source");
   sp_cause_a: assert property ($past(rstn, 3) && $changed(active_sp)
      |-> $past(kick) || $past(kick, 2) || $past(kick, 3))
      else $error("setpoint moved without cause");
   occ_cause_a: assert property ($changed(unocc_icon)
      |-> $past(kick, 2) || $past(kick, 3))
      else $error("occupancy moved without cause");
endmodule // smtc_top_properties

bind smtc_top smtc_top_properties #(.MENU_CYC(MENU_CYC)) chk (.*);

// *** sim/smtc_supervisor.sv ***
// Network supervisor model driving the register port.
`timescale 1ns/1ps

// ==========================================================
// Supervisor
module smtc_supervisor (
   // Clock.
   input wire        clock,
   // Register port.
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata,
   output reg        reg_wr,
   output reg        reg_rd,
   input  wire [7:0] reg_rdata
);
   // Idle bus at time zero.
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // One-cycle write; setpoint and changeover objects go through here.
   task wr(input [7:0] a, input [7:0] v);
   begin
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_wdata <= ~v;
   end
   endtask

   // One-cycle read; data is taken at the edge that closes the answer slot.
   task rd(input [7:0] a, output [7:0] v);
   begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      v = reg_rdata;
   end
   endtask
endmodule // smtc_supervisor

// *** sim/test_single_mode_thermostat_control.sv ***
// Self-checking testbench of the thermostat control block.
`timescale 1ns/1ps
`include "smtc_map.vh"

// ==========================================================
// Testbench
module test_single_mode_thermostat_control;
   localparam MENU = 20;
   localparam WIN  = 50;
   reg        clock, rstn, factory_reset, demand, fan_req;
   reg  [5:0] btns;
   reg  [7:0] room_temp, d, sp_h, sp_c, sp_u;
   wire [7:0] reg_addr, reg_wdata, reg_rdata, active_sp, disp_value;
   wire       reg_wr, reg_rd, heat_out, cool_out, fan_out;
   wire       auto_icon, menu_active, unocc_icon;
   integer    fail_count, checks_done, seed;

   smtc_top #(.MENU_CYC(MENU), .WINDOW_CYC(WIN), .FANOFF_CYC(30), .BLINK_CYC(4)) uut (
      .clock(clock), .rstn(rstn), .btn_mode(btns[0]), .btn_fan(btns[1]),
      .btn_up(btns[2]), .btn_down(btns[3]), .btn_set(btns[4]), .btn_power(btns[5]),
      .factory_reset(factory_reset), .room_temp(room_temp), .demand(demand),
      .fan_delay_req(fan_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .heat_out(heat_out),
      .cool_out(cool_out), .fan_out(fan_out), .active_sp(active_sp),
      .disp_value(disp_value), .auto_icon(auto_icon), .menu_active(menu_active),
      .unocc_icon(unocc_icon));
   smtc_supervisor sup (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // Setpoint in force for a type and occupancy; heat type gives sp_h whatever the occupancy.
   function [7:0] pick_sp(input [1:0] t, input u);
      pick_sp = (t == `SMTC_TYPE_COOL) ? (u ? sp_u : sp_c) : sp_h;
   endfunction

   // Compare and count.
   task chk(input [8*8-1:0] n, input [7:0] seen, input [7:0] exp);
   begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         $display("unexpected %0s expected %h seen %h", n, exp, seen);
         fail_count = fail_count + 1;
      end
   end
   endtask

   // One-cycle button pulse, then a quiet cycle.
   task press(input integer i);
   begin
      @(posedge clock);
      btns <= 6'h01 << i;
      @(posedge clock);
      btns <= 6'h00;
   end
   endtask

   task automatic idle(input integer n);
      repeat (n) @(posedge clock);
   endtask

   task report_and_stop;
   begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask

   // Free-running clock, 100 ns period.
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Watchdog sized well above the few hundred cycles the run needs.
   initial
   begin
      idle(3000);
      fail_count = fail_count + 1;
      report_and_stop;
   end

   // Main sequence.
   initial
   begin
      fail_count = 0;
      checks_done = 0;
      rstn = 1'b0;
      btns = 6'h00;
      factory_reset = 1'b0;
      demand = 1'b0;
      fan_req = 1'b0;
      room_temp = 8'h2C;
      seed = $urandom(32'h1a1c);
      idle(2);
      rstn <= 1'b1;
      sup.rd(`SMTC_A_CTRL, d); chk("ctrl", d, 8'h20);
      sup.rd(`SMTC_A_TYPE, d); chk("type", d, {6'h00, `SMTC_TYPE_HEAT});
      sp_h = 8'h10 + $urandom % 80;
      sp_c = 8'h10 + $urandom % 80;
      sp_u = 8'h10 + $urandom % 80;
      room_temp <= $urandom;
      sup.wr(`SMTC_A_OCC_HEAT, sp_h);
      sup.rd(`SMTC_A_ROOM_TEMP, d); chk("room", d, room_temp);
      chk("disp", disp_value, room_temp);
      idle(2);
      sup.rd(`SMTC_A_ACTIVE_SP, d); chk("sp", d, pick_sp(`SMTC_TYPE_HEAT, 0));
      press(2); press(2); press(3);
      sp_h = sp_h + 8'h01;
      idle(2);
      sup.rd(`SMTC_A_ACTIVE_SP, d); chk("sp", d, pick_sp(`SMTC_TYPE_HEAT, 0));
      // Type write outside the window, then inside it, then after expiry.
      sup.wr(`SMTC_A_TYPE, 8'h01);
      sup.rd(`SMTC_A_TYPE, d); chk("type", d, 8'h02);
      sup.wr(`SMTC_A_OCC_COOL, sp_c);
      sup.wr(`SMTC_A_OPTIONS, 8'h01);
      sup.wr(`SMTC_A_TYPE, 8'h01);
      idle(2);
      sup.rd(`SMTC_A_ACTIVE_SP, d); chk("sp", d, pick_sp(`SMTC_TYPE_COOL, 0));
      idle(WIN - 20);
      sup.wr(`SMTC_A_OPTIONS, 8'h01);
      idle(WIN - 10);
      sup.rd(`SMTC_A_OPTIONS, d); chk("options", d, 8'h01);
      idle(20);
      sup.rd(`SMTC_A_OPTIONS, d); chk("options", d, 8'h00);
      sup.wr(`SMTC_A_TYPE, 8'h02);
      factory_reset <= 1'b1;
      idle(1);
      factory_reset <= 1'b0;
      sup.rd(`SMTC_A_TYPE, d); chk("type", d, 8'h01);
      sp_c = `SMTC_SP_RST;
      sup.wr(`SMTC_A_UNOCC_COOL, sp_u);
      // Occupancy through the panel, then with the set lock on.
      press(4); press(2); press(4);
      idle(3);
      chk("unocc", unocc_icon, 8'h01);
      sup.rd(`SMTC_A_ACTIVE_SP, d); chk("sp", d, pick_sp(`SMTC_TYPE_COOL, 1));
      press(4);
      idle(2);
      chk("menu", menu_active, 8'h01);
      idle(MENU + 5);
      chk("menu", menu_active, 8'h00);
      sup.wr(`SMTC_A_CTRL, 8'h38);
      press(4); press(2); press(4);
      idle(3);
      chk("unocc", unocc_icon, 8'h01);
      // Power, fan in heat and continuous fan.
      demand <= 1'b1;
      idle(3);
      chk("outs", {heat_out, cool_out, fan_out}, 8'h00);
      press(5);
      idle(3);
      chk("outs", {heat_out, cool_out, fan_out}, 8'h03);
      sup.wr(`SMTC_A_OPTIONS, 8'h01);
      sup.wr(`SMTC_A_TYPE, 8'h02);
      idle(3);
      chk("outs", {heat_out, cool_out, fan_out}, 8'h05);
      sup.wr(`SMTC_A_CTRL, 8'h19);
      idle(3);
      chk("outs", {heat_out, cool_out, fan_out}, 8'h04);
      press(1);
      idle(3);
      chk("fan", {auto_icon, fan_out}, 8'h01);
      // Off-delay in automatic mode: fan held, indicator flashing, then fan stops.
      press(1);
      fan_req <= 1'b1;
      idle(1);
      fan_req <= 1'b0;
      idle(3);
      chk("fan", fan_out, 8'h01);
      d = auto_icon;
      idle(4);
      chk("blink", auto_icon, {7'h00, ~d[0]});
      idle(30);
      chk("fan", {auto_icon, fan_out}, 8'h02);
      sup.wr(`SMTC_A_CTRL, 8'h1C);
      idle(3);
      chk("outs", {heat_out, cool_out, fan_out}, 8'h00);
      // Display switched to the setpoint; unoccupied heat is still at its reset value.
      sup.wr(`SMTC_A_CTRL, 8'h5C);
      idle(3);
      chk("disp", disp_value, `SMTC_SP_RST);
      // Local changeover: options set, menu left to time out, then mode and up.
      sup.wr(`SMTC_A_OPTIONS, 8'h01);
      press(0);
      idle(MENU + 2);
      press(0); press(2); press(0);
      sup.rd(`SMTC_A_TYPE, d); chk("type", d, 8'h01);
      report_and_stop;
   end
endmodule // test_single_mode_thermostat_control
